// ### rtl/apc_pkg.sv
// Package for the audio processing configuration bank: map, fields, resets, types.
package apc_pkg;
   localparam logic [7:0] ADDR_PROC_A = 8'h6B;
   localparam logic [7:0] ADDR_PROC_B = 8'h6C;
   localparam logic [7:0] ADDR_RANGE_ENH = 8'h6D;
   localparam logic [7:0] ADDR_AUTO_GAIN = 8'h70;

   localparam logic [7:0] RST_PROC_A = 8'h01;
   localparam logic [7:0] RST_PROC_B = 8'h40;
   localparam logic [7:0] RST_RANGE_ENH = 8'h7B;
   localparam logic [7:0] RST_AUTO_GAIN = 8'hE7;

   // Writable bits; everything else reads zero
   localparam logic [7:0] MASK_PROC_A = 8'h3F;
   localparam logic [7:0] MASK_PROC_B = 8'hFF;

   localparam int DECI_LSB = 4;
   localparam int SUM_LSB = 2;
   localparam int HPF_LSB = 0;
   localparam int GANG_BIT = 7;
   localparam int BIQ_LSB = 5;
   localparam int SOFT_BIT = 4;
   localparam int ALGO_BIT = 3;
   localparam int HI_NIB_LSB = 4;
   localparam int LO_NIB_LSB = 0;

   localparam logic [1:0] CODE_RESERVED2 = 2'h3;
   localparam logic [3:0] ENH_THR_MAX = 4'h9;
   localparam logic [3:0] ENH_GAIN_MAX = 4'hC;
   localparam logic [3:0] AG_GAIN_MAX = 4'hD;

   localparam int NUM_CH = 4;
   localparam int SAMPLE_W = 24;
   localparam int HP_COEF_W = 24;
   // All-pass first-order IIR: b0 = 1.0 (Q1.22), b1 = 0, a1 = 0
   localparam logic [23:0] HP_B0_ALLPASS = 24'h400000;
   localparam logic [23:0] HP_B1_ALLPASS = 24'h000000;
   localparam logic [23:0] HP_A1_ALLPASS = 24'h000000;

   typedef enum logic [1:0] {
      APC_DECI_LINEAR = 2'h0,
      APC_DECI_LOW_LAT = 2'h1,
      APC_DECI_ULTRA_LOW = 2'h2
   } apc_deci_t;

   typedef enum logic [1:0] {
      APC_SUM_OFF = 2'h0,
      APC_SUM_PAIRS = 2'h1,
      APC_SUM_QUAD = 2'h2
   } apc_sum_t;

   typedef enum logic [1:0] {
      APC_HPF_CUSTOM = 2'h0,
      APC_HPF_CUT_A = 2'h1,
      APC_HPF_CUT_B = 2'h2,
      APC_HPF_CUT_C = 2'h3
   } apc_hpf_t;

   typedef enum logic [2:0] {
      APC_BUS_IDLE = 3'b001,
      APC_BUS_WRITE = 3'b010,
      APC_BUS_READ = 3'b100
   } apc_bus_state_t;

   typedef struct packed {
      logic [1:0] decimation_response_sel;
      logic [1:0] channel_summation_sel;
      logic [1:0] highpass_choice;
      logic volume_gang_enable;
      logic [1:0] biquad_count;
      logic soft_step_disable;
      logic gain_algorithm_choice;
      logic [3:0] range_enhancer_threshold;
      logic [3:0] range_enhancer_gain_ceiling;
      logic [3:0] auto_gain_target;
      logic [3:0] auto_gain_ceiling;
   } apc_cfg_t;

   typedef struct packed {
      logic [23:0] b0;
      logic [23:0] b1;
      logic [23:0] a1;
   } apc_hp_coef_t;
endpackage

// ### rtl/apc_summer.sv
// Channel summation stage: pair or quad averaging of four input channels.
`timescale 1ns/10ps
`default_nettype none
module apc_summer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] sum_sel,
   input wire logic in_valid,
   input wire logic [apc_pkg::NUM_CH*apc_pkg::SAMPLE_W-1:0] in_data,
   output logic out_valid,
   output logic [apc_pkg::NUM_CH*apc_pkg::SAMPLE_W-1:0] out_data
);
   localparam int W = apc_pkg::SAMPLE_W;
   logic signed [W+1:0] ch [apc_pkg::NUM_CH];
   logic signed [W+1:0] pair_a;
   logic signed [W+1:0] pair_b;
   logic signed [W+1:0] quad;

   genvar g;
   generate
      for (g = 0; g < apc_pkg::NUM_CH; g++) begin : g_ext
         assign ch[g] = {{2{in_data[g*W+W-1]}}, in_data[g*W +: W]};
      end
   endgenerate

   assign pair_a = (ch[0] + ch[1]) >>> 1;
   assign pair_b = (ch[2] + ch[3]) >>> 1;
   assign quad = (ch[0] + ch[1] + ch[2] + ch[3]) >>> 2;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            case (sum_sel)
               apc_pkg::APC_SUM_PAIRS: begin
                  out_data <= {in_data[3*W +: W], pair_b[W-1:0],
                               in_data[W +: W], pair_a[W-1:0]}; // [R3]
               end
               apc_pkg::APC_SUM_QUAD: begin
                  out_data <= {in_data[3*W +: W], in_data[2*W +: W],
                               in_data[W +: W], quad[W-1:0]}; // [R4]
               end
               default: begin
                  out_data <= in_data; // [R2]
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/apc_volume_sel.sv
// Volume code selection per channel, with ganging to channel one.
`timescale 1ns/10ps
`default_nettype none
module apc_volume_sel (
   input wire logic gang_en,
   input wire logic [apc_pkg::NUM_CH*8-1:0] per_channel_volume,
   output logic [apc_pkg::NUM_CH*8-1:0] effective_volume
);
   genvar g;
   generate
      for (g = 0; g < apc_pkg::NUM_CH; g++) begin : g_vol
         // Channel one's code is used even when channel one is off
         assign effective_volume[g*8 +: 8] = gang_en ? per_channel_volume[7:0]
                                                     : per_channel_volume[g*8 +: 8]; // [R7] [R15]
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/apc_config_bank.sv
// Audio processing configuration bank with its summation and volume stages.
//
// Overview of operation
// R1 - Decimation response select, bits 5-4, code 3 reserved
// R2 - Channel summation select, bits 3-2, zero disables
// R3 - Summation code 1 averages pairs
// R4 - Summation code 2 averages all four
// R5 - Highpass code 0 custom IIR, all-pass reset
// R6 - Highpass select resets 1, fixed cutoffs
// R7 - Gang bit uses channel one volume
// R8 - Biquad count field, reset 2
// R9 - Soft-step disable bit, zero keeps stepping
// R10 - Gain algorithm select: enhancer or auto gain
// R11 - Enhancer threshold, reset 7, code 10+ reserved
// R12 - Enhancer ceiling, reset 11, code 13+ reserved
// R13 - Auto gain target, reset 14
// R14 - Auto gain ceiling, reset 7, code 14+ reserved
// R15 - Volume codes: 0 mute, 201 unity
// R16 - Reserved codes never written; reserved bits read zero (only 6B is masked; 6C bits 2-0 read back as written)
`timescale 1ns/10ps
`default_nettype none
module apc_config_bank (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_hit,
   input wire logic hp_coef_wr,
   input wire logic [1:0] hp_coef_idx,
   input wire logic [apc_pkg::HP_COEF_W-1:0] hp_coef_wdata,
   output apc_pkg::apc_hp_coef_t hp_coef,
   output apc_pkg::apc_cfg_t cfg,
   output logic hpf_custom_active,
   output logic [1:0] hpf_fixed_cut,
   output logic soft_step_active,
   output logic enhancer_active,
   output logic auto_gain_active,
   input wire logic [apc_pkg::NUM_CH*8-1:0] per_channel_volume,
   output logic [apc_pkg::NUM_CH*8-1:0] effective_volume,
   input wire logic smp_valid,
   input wire logic [apc_pkg::NUM_CH*apc_pkg::SAMPLE_W-1:0] smp_data,
   output logic sum_valid,
   output logic [apc_pkg::NUM_CH*apc_pkg::SAMPLE_W-1:0] sum_data
);
   logic [7:0] proc_a_q;
   logic [7:0] proc_b_q;
   logic [7:0] range_enh_q;
   logic [7:0] auto_gain_q;
   logic [apc_pkg::HP_COEF_W-1:0] coef_q [3];
   logic [7:0] rdata_d;
   logic hit_d;
   apc_pkg::apc_bus_state_t bus_state_q;

   always_comb begin
      hit_d = 1'b1;
      rdata_d = 8'h00;
      case (reg_addr)
         apc_pkg::ADDR_PROC_A: rdata_d = proc_a_q & apc_pkg::MASK_PROC_A; // [R16]
         apc_pkg::ADDR_PROC_B: rdata_d = proc_b_q;
         apc_pkg::ADDR_RANGE_ENH: rdata_d = range_enh_q;
         apc_pkg::ADDR_AUTO_GAIN: rdata_d = auto_gain_q;
         default: hit_d = 1'b0;
      endcase
   end

   assign reg_hit = hit_d;

   // Reserved-code writes are stored as given; the summer treats summation code 3 as off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         proc_a_q <= apc_pkg::RST_PROC_A; // [R6]
         proc_b_q <= apc_pkg::RST_PROC_B; // [R8]
         range_enh_q <= apc_pkg::RST_RANGE_ENH; // [R11] [R12]
         auto_gain_q <= apc_pkg::RST_AUTO_GAIN; // [R13] [R14]
      end else if (reg_wr) begin
         case (reg_addr)
            apc_pkg::ADDR_PROC_A: proc_a_q <= reg_wdata & apc_pkg::MASK_PROC_A; // [R1] [R2]
            apc_pkg::ADDR_PROC_B: proc_b_q <= reg_wdata & apc_pkg::MASK_PROC_B; // [R7] [R9]
            apc_pkg::ADDR_RANGE_ENH: range_enh_q <= reg_wdata;
            apc_pkg::ADDR_AUTO_GAIN: auto_gain_q <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_state_q <= apc_pkg::APC_BUS_IDLE;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         case (bus_state_q)
            apc_pkg::APC_BUS_IDLE: begin
               if (reg_rd) begin
                  bus_state_q <= apc_pkg::APC_BUS_READ;
                  reg_rdata <= rdata_d;
                  reg_rvalid <= 1'b1;
               end else if (reg_wr) begin
                  bus_state_q <= apc_pkg::APC_BUS_WRITE;
                  reg_rvalid <= 1'b0;
               end else begin
                  reg_rvalid <= 1'b0;
               end
            end
            apc_pkg::APC_BUS_READ, apc_pkg::APC_BUS_WRITE: begin
               if (reg_rd) begin
                  bus_state_q <= apc_pkg::APC_BUS_READ;
                  reg_rdata <= rdata_d;
                  reg_rvalid <= 1'b1;
               end else begin
                  bus_state_q <= reg_wr ? apc_pkg::APC_BUS_WRITE : apc_pkg::APC_BUS_IDLE;
                  reg_rvalid <= 1'b0;
               end
            end
            default: begin
               bus_state_q <= apc_pkg::APC_BUS_IDLE;
               reg_rvalid <= 1'b0;
            end
         endcase
      end
   end

   // Custom highpass coefficients: b0, b1, a1 at index 0..2
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         coef_q[0] <= apc_pkg::HP_B0_ALLPASS; // [R5]
         coef_q[1] <= apc_pkg::HP_B1_ALLPASS; // [R5]
         coef_q[2] <= apc_pkg::HP_A1_ALLPASS; // [R5]
      end else if (hp_coef_wr && hp_coef_idx != 2'h3) begin
         coef_q[hp_coef_idx] <= hp_coef_wdata;
      end
   end

   assign hp_coef.b0 = coef_q[0];
   assign hp_coef.b1 = coef_q[1];
   assign hp_coef.a1 = coef_q[2];

   assign cfg.decimation_response_sel = proc_a_q[apc_pkg::DECI_LSB +: 2]; // [R1]
   assign cfg.channel_summation_sel = proc_a_q[apc_pkg::SUM_LSB +: 2]; // [R2]
   assign cfg.highpass_choice = proc_a_q[apc_pkg::HPF_LSB +: 2]; // [R6]
   assign cfg.volume_gang_enable = proc_b_q[apc_pkg::GANG_BIT]; // [R7]
   assign cfg.biquad_count = proc_b_q[apc_pkg::BIQ_LSB +: 2]; // [R8]
   assign cfg.soft_step_disable = proc_b_q[apc_pkg::SOFT_BIT]; // [R9]
   assign cfg.gain_algorithm_choice = proc_b_q[apc_pkg::ALGO_BIT]; // [R10]
   assign cfg.range_enhancer_threshold = range_enh_q[apc_pkg::HI_NIB_LSB +: 4]; // [R11]
   assign cfg.range_enhancer_gain_ceiling = range_enh_q[apc_pkg::LO_NIB_LSB +: 4]; // [R12]
   assign cfg.auto_gain_target = auto_gain_q[apc_pkg::HI_NIB_LSB +: 4]; // [R13]
   assign cfg.auto_gain_ceiling = auto_gain_q[apc_pkg::LO_NIB_LSB +: 4]; // [R14]

   assign hpf_custom_active = (cfg.highpass_choice == apc_pkg::APC_HPF_CUSTOM); // [R5]
   assign hpf_fixed_cut = cfg.highpass_choice; // [R6]
   assign soft_step_active = ~cfg.soft_step_disable; // [R9]
   assign enhancer_active = ~cfg.gain_algorithm_choice; // [R10]
   assign auto_gain_active = cfg.gain_algorithm_choice; // [R10]

   apc_volume_sel u_vol (
      .gang_en(cfg.volume_gang_enable),
      .per_channel_volume(per_channel_volume),
      .effective_volume(effective_volume)
   );

   apc_summer u_sum (
      .clk(clk),
      .rst(rst),
      .sum_sel(cfg.channel_summation_sel),
      .in_valid(smp_valid),
      .in_data(smp_data),
      .out_valid(sum_valid),
      .out_data(sum_data)
   );
endmodule
`default_nettype wire

// ### dv/apc_config_bank_props.sv
// Property checker for the audio processing configuration bank ports.
`timescale 1ns/10ps
`default_nettype none
module apc_config_bank_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_hit,
   input wire apc_pkg::apc_cfg_t cfg,
   input wire logic enhancer_active,
   input wire logic [31:0] per_channel_volume,
   input wire logic [31:0] effective_volume,
   input wire logic smp_valid,
   input wire logic sum_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_gang_copy: assert property (cfg.volume_gang_enable |->
      effective_volume == {4{per_channel_volume[7:0]}}) else $error("gang copy wrong");
   chk_own_volume: assert property (!cfg.volume_gang_enable |->
      effective_volume == per_channel_volume) else $error("own volume wrong");
   chk_deci_write: assert property (reg_wr && reg_addr == 8'h6B |=>
      cfg.decimation_response_sel == $past(reg_wdata[5:4])) else $error("decimation field");
   chk_sum_write: assert property (reg_wr && reg_addr == 8'h6B |=>
      cfg.channel_summation_sel == $past(reg_wdata[3:2])) else $error("summation field");
   chk_algo_decode: assert property (enhancer_active == !cfg.gain_algorithm_choice)
      else $error("algorithm decode");
   chk_reserved_zero: assert property (reg_rd && reg_addr == 8'h6B |=>
      reg_rvalid && reg_rdata[7:6] == 2'h0) else $error("reserved bits set");
   chk_unmapped_read: assert property (reg_rd && !reg_hit |=>
      reg_rvalid && reg_rdata == 8'h00) else $error("unmapped read");
   chk_sum_latency: assert property (smp_valid |=> sum_valid)
      else $error("sum latency");
   chk_cfg_hold: assert property (!reg_wr |=> $stable(cfg))
      else $error("config changed without write");
   cover property (reg_wr && reg_addr == 8'h6B);
   cover property (reg_rd && !reg_hit);
   cover property (cfg.volume_gang_enable && smp_valid);
endmodule
bind apc_config_bank apc_config_bank_props i_props (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_rvalid, .reg_hit, .cfg, .enhancer_active, .per_channel_volume,
   .effective_volume, .smp_valid, .sum_valid);
`default_nettype wire

// ### dv/apc_config_bank_tb.sv
// Self-checking bench for the audio processing configuration bank.
`timescale 1ns/10ps
`default_nettype none
module apc_config_bank_tb;
   logic clk, rst, reg_wr, reg_rd, hp_coef_wr, smp_valid, reg_rvalid, reg_hit;
   logic hpf_custom_active, soft_step_active, enhancer_active, auto_gain_active, sum_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] hp_coef_idx, hpf_fixed_cut;
   logic [23:0] hp_coef_wdata;
   apc_pkg::apc_hp_coef_t hp_coef;
   apc_pkg::apc_cfg_t cfg;
   logic [31:0] per_channel_volume, effective_volume;
   logic [95:0] smp_data, sum_data;
   logic [7:0] addrs[5] = '{8'h6B, 8'h6C, 8'h6D, 8'h70, 8'h6E};
   int err_total, compares, seed, k;
   int mdl[int];
   apc_config_bank i_dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .reg_hit, .hp_coef_wr, .hp_coef_idx, .hp_coef_wdata, .hp_coef, .cfg,
      .hpf_custom_active, .hpf_fixed_cut, .soft_step_active, .enhancer_active,
      .auto_gain_active, .per_channel_volume, .effective_volume, .smp_valid, .smp_data,
      .sum_valid, .sum_data);
   task automatic chk(string n, logic [95:0] e, logic [95:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   // Software never writes reserved codes: fold random data onto legal codes
   function automatic logic [7:0] legal(logic [7:0] a, logic [7:0] d);
      logic [7:0] r;
      r = d;
      if (a == 8'h6B && r[5:4] == 2'h3) r[5:4] = 2'h2;
      if (a == 8'h6B && r[3:2] == 2'h3) r[3:2] = 2'h2;
      if (a == 8'h6C) r[2:0] = 3'h0;
      if (a == 8'h6D) r = {4'(r[7:4] % 10), 4'(r[3:0] % 13)};
      if (a == 8'h70) r[3:0] = 4'(r[3:0] % 14);
      return r;
   endfunction
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 0;
      if (mdl.exists(a)) mdl[a] = (a == 8'h6B) ? (d & 8'h3F) : d;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge clk);
      reg_rd = 1;
      reg_addr = a;
      #1 chk("hit", mdl.exists(a), reg_hit);
      @(negedge clk);
      reg_rd = 0;
      chk("rvalid", 1, reg_rvalid);
      chk("rdata", mdl.exists(a) ? mdl[a] : 0, reg_rdata);
   endtask
   task automatic chk_cfg;
      logic [7:0] a, b;
      a = mdl[8'h6B];
      b = mdl[8'h6C];
      chk("cfg", {a[5:0], b[7:3], mdl[8'h6D][7:0], mdl[8'h70][7:0]}, cfg);
      chk("custom", a[1:0] == 2'h0, hpf_custom_active);
      chk("cut", a[1:0], hpf_fixed_cut);
      chk("dre", !b[3], enhancer_active);
      chk("agc", b[3], auto_gain_active);
      chk("soft", !b[4], soft_step_active);
      chk("vol", b[7] ? {4{per_channel_volume[7:0]}} : per_channel_volume,
         effective_volume);
   endtask
   task automatic smp(logic [1:0] m);
      int c[4];
      logic [95:0] e;
      @(negedge clk);
      smp_data = {$random(seed), $random(seed), $random(seed)};
      smp_valid = 1;
      e = smp_data;
      for (int i = 0; i < 4; i++) c[i] = $signed(smp_data[i*24 +: 24]);
      if (m == 2'h1) begin
         e[23:0] = 24'((c[0] + c[1]) >>> 1);
         e[71:48] = 24'((c[2] + c[3]) >>> 1);
      end
      if (m == 2'h2) e[23:0] = 24'((c[0] + c[1] + c[2] + c[3]) >>> 2);
      @(negedge clk);
      smp_valid = 0;
      chk("sum_valid", 1, sum_valid);
      chk("sum_data", e, sum_data);
   endtask
   task automatic do_reset;
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      mdl[8'h6B] = 8'h01;
      mdl[8'h6C] = 8'h40;
      mdl[8'h6D] = 8'h7B;
      mdl[8'h70] = 8'hE7;
      chk("coef", {24'h400000, 48'h0}, hp_coef);
      foreach (addrs[i]) rd(addrs[i]);
      chk_cfg;
   endtask
   task automatic summarize;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // Whole sequence needs well under 1000 cycles
   initial begin
      #100000;
      err_total++;
      summarize;
   end
   initial begin
      seed = 45;
      {reg_wr, reg_rd, hp_coef_wr, smp_valid, reg_addr, reg_wdata} = 0;
      {hp_coef_idx, hp_coef_wdata, smp_data} = 0;
      per_channel_volume = 32'h000000C9;
      do_reset;
      @(negedge clk);
      hp_coef_wr = 1;
      hp_coef_idx = 2'h1;
      hp_coef_wdata = 24'h123456;
      @(negedge clk);
      hp_coef_wr = 0;
      chk("coef_b1", 24'h123456, hp_coef.b1);
      @(negedge clk);
      hp_coef_wr = 1;
      hp_coef_idx = 2'h3;
      hp_coef_wdata = 24'hABCDEF;
      @(negedge clk);
      hp_coef_wr = 0;
      chk("coef_idx3", {24'h400000, 24'h123456, 24'h000000}, hp_coef);
      repeat (40) begin
         k = $unsigned($random(seed)) % 5;
         wr(addrs[k], legal(addrs[k], 8'($random(seed))));
         per_channel_volume = $random(seed);
         rd(addrs[k]);
         chk_cfg;
      end
      // Code 3 is reserved; the last pass returns to summation off
      for (int m = 0; m < 4; m++) begin
         wr(8'h6B, 8'((m % 3) << 2));
         repeat (3) smp(2'(m % 3));
      end
      do_reset;
      summarize;
   end
endmodule
`default_nettype wire
